// file: shared/dactg_regs.vh
// register offsets, field positions and reset values for the tx gate and misc control bank
`ifndef DACTG_REGS_VH
`define DACTG_REGS_VH
`define DACTG_ADDR_PAGE        12'h008
`define DACTG_ADDR_PWR_LOW     12'h58B
`define DACTG_ADDR_PWR_HIGH    12'h58C
`define DACTG_ADDR_TXSM        12'h58D
`define DACTG_ADDR_BLANK       12'h596
`define DACTG_ADDR_IRQ_LOW     12'h597
`define DACTG_ADDR_IRQ_HIGH    12'h598
`define DACTG_ADDR_FLUSH       12'h599
`define DACTG_ADDR_BOOT        12'h705
`define DACTG_ADDR_PLLPD0      12'h790
`define DACTG_BIT_SOFT_OVR     2
`define DACTG_BIT_SOFT_VAL     3
`define DACTG_RSVD_TXSM        7'h01
`define DACTG_RST_BLANK        2'h0
`define DACTG_RST_IRQ          9'h000
`define DACTG_RST_FLUSH        1'h1
`define DACTG_RST_PLLPD0       8'h00
`define DACTG_RST_PAGE         2'h1
`define DACTG_SAMPLE_MSBS      6
`define DACTG_PA_DIV_INTERP    9'h008
`define DACTG_PA_DIV_PLAIN     9'h020
`endif

// file: src/dactg_ctrl_regs.v
// tx gate, link protection irq enables, flush, boot loader and pll power-down registers
`timescale 1ns/1ps
`default_nettype none
`include "dactg_regs.vh"
module dactg_ctrl_regs (
  input  wire        i_sys_clk,        // register clock, 125 mhz
  input  wire        i_rstn,           // async reset, active low
  input  wire        i_wr,             // write strobe, one cycle
  input  wire        i_rd,             // read strobe, one cycle
  input  wire [11:0] i_addr,           // register address
  input  wire [7:0]  i_wdata,          // write data
  output reg  [7:0]  o_rdata,          // read data, valid cycle after i_rd
  input  wire [5:0]  i_samp_i_0,       // path 0 in-phase sample msbs
  input  wire [5:0]  i_samp_q_0,       // path 0 quadrature sample msbs
  input  wire [5:0]  i_samp_i_1,       // path 1 in-phase sample msbs
  input  wire [5:0]  i_samp_q_1,       // path 1 quadrature sample msbs
  input  wire [1:0]  i_tx_gate_input,  // external tx enable per path
  output reg  [1:0]  o_tx_gate_status, // resolved tx gate per path
  output reg  [1:0]  o_tx_gate_fsm_enable, // fsm enable per path
  output reg  [1:0]  o_flush_enable,   // datapath flush enable per path
  input  wire [8:0]  i_link_event,     // link protection event pulses
  output reg         o_link_irq,       // link protection interrupt
  output reg         o_boot_loader_start, // boot loader running level
  input  wire        i_boot_done,      // loader finished or failed pulse
  output reg  [7:0]  o_pll_powerdown,  // pll power-down bits
  input  wire        i_chan_interp_gt1, // channel interpolation above one
  input  wire [3:0]  i_main_interp,    // main interpolation factor
  output reg  [8:0]  o_pa_clk_div      // protection clock divide, dac clocks
);

  // squared magnitude of two six-bit signed samples
  // only the sample msbs reach this block, which keeps each
  // multiplier at six by six bits; the discarded lsbs are the price
  // largest square is 1024, so twelve bits per term cannot overflow
  function [12:0] pwr_calc;
    input [5:0] si;
    input [5:0] sq;
    reg signed [11:0] pi;
    reg signed [11:0] pq;
    begin
      pi = $signed(si) * $signed(si);
      pq = $signed(sq) * $signed(sq);
      pwr_calc = {1'b0, pi[11:0]} + {1'b0, pq[11:0]};
    end
  endfunction

  // control state; paged fields keep one bit per main path
  reg  [1:0]  main_path_page_select; // bit per path, both may be set
  reg  [12:0] average_power_short [0:1]; // per-path power result
  reg  [1:0]  tx_gate_fsm_enable;    // per path
  reg  [1:0]  soft_tx_gate_override; // per path
  reg  [1:0]  soft_tx_gate_value;    // per path
  reg  [1:0]  flush_en;              // per path
  reg  [8:0]  link_protect_irq_mask; // shared, not paged
  reg         boot_loader_start;     // self clearing
  reg  [7:0]  pll_pd;                // pll power-down bits
  reg  [7:0]  next_rdata;            // read mux result
  wire        rd_sel;                // path shown on paged reads
  wire [8:0]  pa_div_scaled;         // 8 times main interpolation
  integer     p;                     // paged write loop index

  // lowest selected page answers reads; none selected reads path 0
  // with both pages selected a read cannot show two values, so path 0 wins
  assign rd_sel = (main_path_page_select == 2'h2) ? 1'b1 : 1'b0;

  // nine-bit product; the largest factor of 15 gives 120, well in range
  assign pa_div_scaled = `DACTG_PA_DIV_INTERP * {5'h00, i_main_interp};

  // power detect from six msbs per path
  // refreshed every cycle, so a read shows the previous cycle's samples
  // the two halves come from separate reads and may straddle an update
  // reset clears both, so the readback starts at zero
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      average_power_short[0] <= 13'h0000;
      average_power_short[1] <= 13'h0000;
    end else begin
      average_power_short[0] <= pwr_calc(i_samp_i_0, i_samp_q_0);
      average_power_short[1] <= pwr_calc(i_samp_i_1, i_samp_q_1);
    end
  end

  // register writes; paged fields update each selected path
  // a new page select applies from the access after its own write
  // shared registers ignore the page, so either path may reach them
  // writes to the power readback fall through to the default and are lost
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      main_path_page_select <= `DACTG_RST_PAGE;
      tx_gate_fsm_enable    <= 2'h0;
      soft_tx_gate_override <= `DACTG_RST_BLANK;
      soft_tx_gate_value    <= `DACTG_RST_BLANK;
      flush_en              <= {2{`DACTG_RST_FLUSH}};
      link_protect_irq_mask <= `DACTG_RST_IRQ;
      boot_loader_start     <= 1'b0;
      pll_pd                <= `DACTG_RST_PLLPD0;
    end else begin
      // loader completion clears the start bit; a same-cycle write of one restarts it
      // the write case below comes later in the block, so it has the last word
      // writing zero never stops a running loader; only completion clears it
      if (i_boot_done) begin
        boot_loader_start <= 1'b0;
      end
      if (i_wr) begin
        case (i_addr)
          `DACTG_ADDR_PAGE: begin
            main_path_page_select <= i_wdata[1:0];
          end
          `DACTG_ADDR_IRQ_LOW: begin
            link_protect_irq_mask[7:0] <= i_wdata;
          end
          `DACTG_ADDR_IRQ_HIGH: begin
            link_protect_irq_mask[8] <= i_wdata[0];
          end
          `DACTG_ADDR_BOOT: begin
            if (i_wdata[0]) begin
              boot_loader_start <= 1'b1;
            end
          end
          `DACTG_ADDR_PLLPD0: begin
            pll_pd <= i_wdata;
          end
          default: begin
            // paged registers: write every selected path
            for (p = 0; p < 2; p = p + 1) begin
              if (main_path_page_select[p]) begin
                if (i_addr == `DACTG_ADDR_TXSM) begin
                  tx_gate_fsm_enable[p] <= i_wdata[0];
                end
                if (i_addr == `DACTG_ADDR_BLANK) begin
                  soft_tx_gate_override[p] <= i_wdata[`DACTG_BIT_SOFT_OVR];
                  soft_tx_gate_value[p]    <= i_wdata[`DACTG_BIT_SOFT_VAL];
                end
                if (i_addr == `DACTG_ADDR_FLUSH) begin
                  flush_en[p] <= i_wdata[0];
                end
              end
            end
          end
        endcase
      end
    end
  end

  // read mux; reserved bits read as stated, unmapped reads zero
  // combinational only; o_rdata is loaded on the read strobe alone,
  // so the last read value stays visible until the next read
  always @* begin
    next_rdata = 8'h00;
    case (i_addr)
      `DACTG_ADDR_PAGE:     next_rdata = {6'h00, main_path_page_select};
      `DACTG_ADDR_PWR_LOW:  next_rdata = average_power_short[rd_sel][7:0];
      `DACTG_ADDR_PWR_HIGH: next_rdata = {3'h0, average_power_short[rd_sel][12:8]};
      `DACTG_ADDR_TXSM:     next_rdata = {`DACTG_RSVD_TXSM,
                                          tx_gate_fsm_enable[rd_sel]};
      `DACTG_ADDR_BLANK:    next_rdata = {4'h0, soft_tx_gate_value[rd_sel],
                                          soft_tx_gate_override[rd_sel], 2'h0};
      `DACTG_ADDR_IRQ_LOW:  next_rdata = link_protect_irq_mask[7:0];
      `DACTG_ADDR_IRQ_HIGH: next_rdata = {7'h00, link_protect_irq_mask[8]};
      `DACTG_ADDR_FLUSH:    next_rdata = {7'h00, flush_en[rd_sel]};
      `DACTG_ADDR_BOOT:     next_rdata = {7'h00, boot_loader_start};
      `DACTG_ADDR_PLLPD0:   next_rdata = pll_pd;
      default:              next_rdata = 8'h00;
    endcase
  end

  // registered outputs
  // every control output is a flip-flop so the datapath never sees
  // decode glitches; the cost is one cycle between store and effect
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata              <= 8'h00;
      o_tx_gate_status     <= 2'h0;
      o_tx_gate_fsm_enable <= 2'h0;
      o_flush_enable       <= 2'h3;
      o_link_irq           <= 1'b0;
      o_boot_loader_start  <= 1'b0;
      o_pll_powerdown      <= 8'h00;
      o_pa_clk_div         <= `DACTG_PA_DIV_PLAIN;
    end else begin
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
      // software value replaces the pin while overriding
      // the pin is used as is; it is taken to be synchronous to this clock
      // per path and bitwise, so each path can be overridden on its own
      o_tx_gate_status <= (soft_tx_gate_override & soft_tx_gate_value) |
                          (~soft_tx_gate_override & i_tx_gate_input);
      o_tx_gate_fsm_enable <= tx_gate_fsm_enable;
      o_flush_enable       <= flush_en;
      // interrupt is one-cycle per unmasked event
      // no sticky status: an event that arrives while masked is lost,
      // and whoever listens must catch the single-cycle pulse
      o_link_irq <= |(i_link_event & link_protect_irq_mask);
      o_boot_loader_start <= boot_loader_start;
      o_pll_powerdown     <= pll_pd;
      // protection clock period in dac clock periods
      // the interpolation level is taken as stable; a change shows next cycle
      if (i_chan_interp_gt1) begin
        o_pa_clk_div <= pa_div_scaled;
      end else begin
        o_pa_clk_div <= `DACTG_PA_DIV_PLAIN;
      end
    end
  end

endmodule
`default_nettype wire

// file: sim/dactg_host.sv
// host model that issues register accesses on the control port
`timescale 1ns/1ps
`default_nettype none
module dactg_host (
  input  wire logic        i_sys_clk,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [11:0] o_addr,
  output var  logic [7:0]  o_wdata
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 12'h000;
    o_wdata = 8'h00;
  end
  // strobe held over one sampling edge, then bus scrambled so no stale value lingers
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_wr = w;
    o_rd = !w;
    o_addr = a;
    o_wdata = d;
    @(posedge i_sys_clk);
    #1;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    @(posedge i_sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: sim/dactg_ctrl_regs_assertions.sv
// port-level checks for the tx gate and misc control bank
`timescale 1ns/1ps
`default_nettype none
module dactg_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rstn,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [11:0] i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic [8:0]  i_link_event,
  input wire logic        o_link_irq,
  input wire logic        i_boot_done,
  input wire logic        o_boot_loader_start,
  input wire logic [7:0]  o_pll_powerdown,
  input wire logic        i_chan_interp_gt1,
  input wire logic [3:0]  i_main_interp,
  input wire logic [8:0]  o_pa_clk_div
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // loader finish with no competing start write
  sequence s_boot_clr;
    i_boot_done && !(i_wr && i_addr == 12'h705);
  endsequence
  property p_irq; o_link_irq |-> $past(i_link_event) != 9'h000; endproperty
  property p_div8; $past(i_chan_interp_gt1) |-> o_pa_clk_div == {2'h0, $past(i_main_interp), 3'h0}; endproperty
  property p_div32; !$past(i_chan_interp_gt1) |-> o_pa_clk_div == 9'd32; endproperty
  property p_pwr; $past(i_rd && i_addr == 12'h58C) |-> o_rdata[7:5] == 3'h0; endproperty
  property p_txsm; $past(i_rd && i_addr == 12'h58D) |-> o_rdata[7:1] == 7'h01; endproperty
  property p_irqhi; $past(i_rd && i_addr == 12'h598) |-> o_rdata[7:1] == 7'h00; endproperty
  property p_flush; $past(i_rd && i_addr == 12'h599) |-> o_rdata[7:1] == 7'h00; endproperty
  property p_boot; s_boot_clr |-> ##2 !o_boot_loader_start; endproperty
  property p_pll; i_wr && i_addr == 12'h790 |-> ##2 o_pll_powerdown == $past(i_wdata, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq without event");
  a_div8: assert property (p_div8) else $error("bad interp divide");
  a_div32: assert property (p_div32) else $error("bad plain divide");
  a_pwr: assert property (p_pwr) else $error("power high byte spill");
  a_txsm: assert property (p_txsm) else $error("fsm reserved bits");
  a_irqhi: assert property (p_irqhi) else $error("irq high reserved");
  a_flush: assert property (p_flush) else $error("flush reserved");
  a_boot: assert property (p_boot) else $error("boot not cleared");
  a_pll: assert property (p_pll) else $error("pll bits not stored");
endmodule
bind dactg_ctrl_regs dactg_chk chk_u (.i_sys_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata,
  .o_rdata, .i_link_event, .o_link_irq, .i_boot_done, .o_boot_loader_start, .o_pll_powerdown,
  .i_chan_interp_gt1, .i_main_interp, .o_pa_clk_div);
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the tx gate and misc control bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_sys_clk, i_rstn, i_wr, i_rd, o_link_irq, i_boot_done, o_boot_loader_start;
  logic i_chan_interp_gt1;
  logic [11:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_pll_powerdown;
  logic [5:0] i_samp_i_0, i_samp_q_0, i_samp_i_1, i_samp_q_1;
  logic [1:0] i_tx_gate_input, o_tx_gate_status, o_tx_gate_fsm_enable, o_flush_enable;
  logic [8:0] i_link_event, o_pa_clk_div, en;
  logic [3:0] i_main_interp;
  int failures, checked;
  // reset image: addresses and values, last one unmapped
  logic [11:0] ra [9] = '{12'h58C, 12'h58D, 12'h596, 12'h597, 12'h598, 12'h599, 12'h705, 12'h790, 12'h123};
  logic [7:0] rv [9] = '{8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
  dactg_ctrl_regs dut_u (
    .i_sys_clk            (i_sys_clk),
    .i_rstn               (i_rstn),
    .i_wr                 (i_wr),
    .i_rd                 (i_rd),
    .i_addr               (i_addr),
    .i_wdata              (i_wdata),
    .o_rdata              (o_rdata),
    .i_samp_i_0           (i_samp_i_0),
    .i_samp_q_0           (i_samp_q_0),
    .i_samp_i_1           (i_samp_i_1),
    .i_samp_q_1           (i_samp_q_1),
    .i_tx_gate_input      (i_tx_gate_input),
    .o_tx_gate_status     (o_tx_gate_status),
    .o_tx_gate_fsm_enable (o_tx_gate_fsm_enable),
    .o_flush_enable       (o_flush_enable),
    .i_link_event         (i_link_event),
    .o_link_irq           (o_link_irq),
    .o_boot_loader_start  (o_boot_loader_start),
    .i_boot_done          (i_boot_done),
    .o_pll_powerdown      (o_pll_powerdown),
    .i_chan_interp_gt1    (i_chan_interp_gt1),
    .i_main_interp        (i_main_interp),
    .o_pa_clk_div         (o_pa_clk_div)
  );
  dactg_host host_u (.i_sys_clk, .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host_u.acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    host_u.acc(1'b0, a, 8'h00);
    check({1'b0, o_rdata}, {1'b0, e});
  endtask
  // one-cycle pulse on event or loader-done lines, irq looked at in its only cycle
  task automatic pulse(input logic [8:0] ev, input logic d, input logic exp);
    @(posedge i_sys_clk);
    #1;
    i_link_event = ev;
    i_boot_done = d;
    @(posedge i_sys_clk);
    #1;
    i_link_event = 9'h000;
    i_boot_done = 1'b0;
    if (!d) check({8'h00, o_link_irq}, {8'h00, exp});
  endtask
  task automatic stop_test;
    if (failures == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    {i_rstn, i_boot_done, i_chan_interp_gt1, i_main_interp, i_link_event} = '0;
    {i_samp_i_0, i_samp_q_0, i_samp_i_1, i_samp_q_1} = 24'h000000;
    i_tx_gate_input = 2'h2;
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_rstn = 1'b1;
    for (int k = 0; k < 9; k++) rd(ra[k], rv[k]);
    check({7'h00, o_flush_enable}, 9'h003);
    check(o_pa_clk_div, 9'h020);
    {i_samp_i_0, i_samp_q_0, i_samp_i_1, i_samp_q_1} = {6'h20, 6'h1F, 6'h20, 6'h20};
    rd(12'h58B, 8'hC1);
    rd(12'h58C, 8'h07);
    wr(12'h008, 8'h02);
    rd(12'h58C, 8'h08);
    wr(12'h008, 8'h01);
    check({7'h00, o_tx_gate_status}, 9'h002);
    wr(12'h596, 8'h0C);
    check({7'h00, o_tx_gate_status}, 9'h003);
    wr(12'h596, 8'h04);
    check({7'h00, o_tx_gate_status}, 9'h002);
    wr(12'h58D, 8'h01);
    check({7'h00, o_tx_gate_fsm_enable}, 9'h001);
    rd(12'h58D, 8'h03);
    wr(12'h599, 8'h00);
    check({7'h00, o_flush_enable}, 9'h002);
    for (int k = 0; k < 9; k++) begin
      en = 9'h001 << k;
      wr(12'h597, en[7:0]);
      wr(12'h598, {7'h00, en[8]});
      pulse(~en, 1'b0, 1'b0);
      pulse(en, 1'b0, 1'b1);
    end
    wr(12'h705, 8'h01);
    check({8'h00, o_boot_loader_start}, 9'h001);
    pulse(9'h000, 1'b1, 1'b0);
    rd(12'h705, 8'h00);
    check({8'h00, o_boot_loader_start}, 9'h000);
    wr(12'h790, 8'h70);
    rd(12'h790, 8'h70);
    check({1'b0, o_pll_powerdown}, 9'h070);
    {i_chan_interp_gt1, i_main_interp} = 5'h13;
    repeat (2) @(posedge i_sys_clk);
    #1;
    check(o_pa_clk_div, 9'h018);
    wr(12'h123, 8'hFF);
    rd(12'h123, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
